// ### tefl_pkg.sv
package tefl_pkg;
    localparam int ADR_W = 10;
    localparam int DAT_W = 32;
    localparam int IDX_W = 8;
    localparam int DB_W = 8;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_OUTSIDE_STATUS = 8'h2D;
    localparam logic [IDX_W-1:0] IDX_WINDOW_STATUS = 8'h2E;
    localparam logic [IDX_W-1:0] IDX_CONFIG_A = 8'h2F;
    localparam logic [IDX_W-1:0] IDX_UPPER_THRESHOLD = 8'h40;
    localparam logic [IDX_W-1:0] IDX_LOWER_THRESHOLD = 8'h41;
    localparam logic [IDX_W-1:0] IDX_INSIDE_DEBOUNCE = 8'h42;
    localparam logic [IDX_W-1:0] IDX_OUTSIDE_DEBOUNCE = 8'h43;

    // Configuration field positions
    localparam int CFG_OUTSIDE_LATCH = 7;
    localparam int CFG_INSIDE_LATCH = 6;
    localparam int CFG_OUTSIDE_EN_LSB = 3;
    localparam int CFG_INSIDE_EN_LSB = 0;

    // Status field positions
    localparam int ST_ACTIVE = 7;
    localparam int ST_X = 5;
    localparam int ST_Y = 3;
    localparam int ST_Z = 1;

    // Configuration reset values by strap level
    localparam logic [7:0] CFG_RESET_STRAP_LOW = 8'h00;
    localparam logic [7:0] CFG_RESET_STRAP_HIGH = 8'h38;
    localparam logic [DB_W-1:0] DB_RESET = 8'h00;
    localparam logic [1:0] BOOT_SETTLE_CYCLES = 2'h3;

    typedef enum logic [0:0] {
        BOOT_SETTLE,
        BOOT_RUN
    } tefl_boot_e;
endpackage : tefl_pkg

// ### tefl_event_class.sv
module tefl_event_class
    import tefl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic [2:0] axis_hit,
    input wire logic latch_en,
    input wire logic [DB_W-1:0] db_count,
    input wire logic clear,
    output logic active,
    output logic [2:0] axis_flags
);
    logic [DB_W-1:0] run;
    logic qual_prev;
    logic cond;
    logic [DB_W-1:0] next_run;
    logic qual_now;
    logic rise;
    logic next_active;
    logic [2:0] next_flags;

    assign cond = |axis_hit;
    assign next_run = !cond ? '0 : (&run) ? run : run + 1'b1;
    assign qual_now = cond && (next_run >= db_count);
    // Edge only; condition must fall before next event
    assign rise = tick && qual_now && !qual_prev;

    always_comb begin
        next_active = active;
        next_flags = axis_flags;
        if (latch_en) begin
            // Set wins over the read clear
            if (rise) begin
                next_active = 1'b1;
                next_flags = axis_flags | axis_hit;
            end else if (clear) begin
                next_active = 1'b0;
                next_flags = 3'h0;
            end
        end else if (tick) begin
            next_active = qual_now;
            // Real time, or every tick with zero debounce
            if (qual_now || db_count == '0) begin
                next_flags = axis_hit;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            run <= '0;
            qual_prev <= 1'b0;
            active <= 1'b0;
            axis_flags <= 3'h0;
        end else if (ce) begin
            if (tick) begin
                run <= next_run;
                qual_prev <= qual_now;
            end
            active <= next_active;
            axis_flags <= next_flags;
        end
    end
endmodule : tefl_event_class

// ### tefl_flag_latch.sv
// Notes on behaviour
// - Z inside flag is 1 when Z strictly between lower and upper thresholds.
// - Inside latching on: axis flags captured when active rises, held until status read.
// - Inside latching off, nonzero debounce: axis flags update only while active and debounce reached.
// - Inside latching off, zero debounce: axis flags update every sample tick regardless.
// - Config is eight read/write bits; reset zero, or outside enables set with strap high.
// - Outside latching on: outside axis flags cleared only by outside status read.
// - Outside latching on: active asserts on false-to-true edge only.
// - Outside latching off: outside axis flags update only while active and debounce reached, or every sample tick with zero debounce.
// - Inside latching on: active asserts on false-to-true edge only.
// - Outside enable bits include or exclude each axis from outside evaluation.
//
// The Wishbone slave port was chosen for this implementation.
module tefl_flag_latch
    import tefl_pkg::*;
#(
    parameter int AXIS_W = 12
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic boot_strap_pin,
    input wire logic sample_valid,
    input wire logic [AXIS_W-1:0] axis_x,
    input wire logic [AXIS_W-1:0] axis_y,
    input wire logic [AXIS_W-1:0] axis_z,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [DAT_W-1:0] wb_dat_w,
    output logic [DAT_W-1:0] wb_dat_r,
    output logic wb_ack,
    output logic inside_active_flag,
    output logic outside_active_flag
);
    if (AXIS_W < 2 || AXIS_W > 24) begin : g_bad_width
        $error("AXIS_W must lie between 2 and 24");
    end
    // Read path packs 8-bit fields into a 32-bit word
    if (DAT_W != 32 || DB_W != 8) begin : g_bad_bus
        $error("Data bus must be 32 bits and debounce counts 8 bits");
    end
    // Register index is the word part of the byte address
    if (IDX_W != ADR_W - 2) begin : g_bad_index
        $error("Index width must match the word address");
    end


    logic [7:0] change_detect_config_a;
    logic [AXIS_W-1:0] upper_threshold;
    logic [AXIS_W-1:0] lower_threshold;
    logic [DB_W-1:0] inside_debounce_count;
    logic [DB_W-1:0] outside_debounce_count;
    logic strap_s1;
    logic strap_s2;
    logic strap_s3;
    logic [1:0] settle;
    tefl_boot_e boot_state;

    logic [AXIS_W-1:0] axis_data [3];
    logic [2:0] axis_inside;
    logic [2:0] axis_outside;
    logic [2:0] inside_hit;
    logic [2:0] outside_hit;
    logic [2:0] axis_inside_flags;
    logic [2:0] axis_outside_flags;

    wire [IDX_W-1:0] reg_idx = wb_adr[ADR_W-1:2];
    // A held strobe is not taken twice
    wire req = wb_cyc && wb_stb && !wb_ack;
    // Write lands at the edge where the master samples ack
    wire wr = wb_cyc && wb_stb && wb_ack && wb_we && wb_sel[0];
    // Read clear at the taking edge, so a same-edge set still wins
    wire rd = req && !wb_we;
    wire hit_out_st = (reg_idx == IDX_OUTSIDE_STATUS);
    wire hit_win_st = (reg_idx == IDX_WINDOW_STATUS);
    wire hit_cfg = (reg_idx == IDX_CONFIG_A);
    wire hit_upper = (reg_idx == IDX_UPPER_THRESHOLD);
    wire hit_lower = (reg_idx == IDX_LOWER_THRESHOLD);
    wire hit_in_db = (reg_idx == IDX_INSIDE_DEBOUNCE);
    wire hit_out_db = (reg_idx == IDX_OUTSIDE_DEBOUNCE);
    wire strap_stable = (strap_s2 == strap_s3);
    wire [AXIS_W-1:0] thr_wdata = wb_dat_w[AXIS_W-1:0];
    wire settle_done = (settle == BOOT_SETTLE_CYCLES);

    // One write strobe per register
    wire wr_cfg = wr && hit_cfg;
    wire wr_upper = wr && hit_upper;
    wire wr_lower = wr && hit_lower;
    wire wr_in_db = wr && hit_in_db;
    wire wr_out_db = wr && hit_out_db;

    wire clear_inside = rd && hit_win_st;
    wire clear_outside = rd && hit_out_st;

    wire outside_latch_enable = change_detect_config_a[CFG_OUTSIDE_LATCH];
    wire inside_latch_enable = change_detect_config_a[CFG_INSIDE_LATCH];
    wire x_outside_enable = change_detect_config_a[CFG_OUTSIDE_EN_LSB + 2];
    wire y_outside_enable = change_detect_config_a[CFG_OUTSIDE_EN_LSB + 1];
    wire z_outside_enable = change_detect_config_a[CFG_OUTSIDE_EN_LSB];
    wire x_inside_enable = change_detect_config_a[CFG_INSIDE_EN_LSB + 2];
    wire y_inside_enable = change_detect_config_a[CFG_INSIDE_EN_LSB + 1];
    wire z_inside_enable = change_detect_config_a[CFG_INSIDE_EN_LSB];
    // Bit order X, Y, Z from high to low
    wire [2:0] inside_enables = {x_inside_enable, y_inside_enable, z_inside_enable};
    wire [2:0] outside_enables = {x_outside_enable, y_outside_enable, z_outside_enable};

    // Index 0 is Z, index 2 is X
    assign axis_data[0] = axis_z;
    assign axis_data[1] = axis_y;
    assign axis_data[2] = axis_x;

    for (genvar i = 0; i < 3; i++) begin : g_axis
        // Edges count as outside
        assign axis_inside[i] = ($signed(axis_data[i]) < $signed(upper_threshold))
            && ($signed(axis_data[i]) > $signed(lower_threshold));
        assign axis_outside[i] = !axis_inside[i];
    end

    // Per-axis participation enables
    assign inside_hit = axis_inside & inside_enables;
    assign outside_hit = axis_outside & outside_enables;

    tefl_event_class u_inside (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .tick(sample_valid),
        .axis_hit(inside_hit),
        .latch_en(inside_latch_enable),
        .db_count(inside_debounce_count),
        .clear(clear_inside),
        .active(inside_active_flag),
        .axis_flags(axis_inside_flags)
    );

    tefl_event_class u_outside (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .tick(sample_valid),
        .axis_hit(outside_hit),
        .latch_en(outside_latch_enable),
        .db_count(outside_debounce_count),
        .clear(clear_outside),
        .active(outside_active_flag),
        .axis_flags(axis_outside_flags)
    );

    logic [7:0] win_status;
    logic [7:0] out_status;
    // Z flag in its own bit
    wire z_inside_flag = axis_inside_flags[0];
    wire y_inside_flag = axis_inside_flags[1];
    wire x_inside_flag = axis_inside_flags[2];
    wire z_outside_flag = axis_outside_flags[0];
    wire y_outside_flag = axis_outside_flags[1];
    wire x_outside_flag = axis_outside_flags[2];

    // Status layout; spare bits read zero
    always_comb begin
        win_status = 8'h00;
        win_status[ST_ACTIVE] = inside_active_flag;
        win_status[ST_X] = x_inside_flag;
        win_status[ST_Y] = y_inside_flag;
        win_status[ST_Z] = z_inside_flag;
    end

    always_comb begin
        out_status = 8'h00;
        out_status[ST_ACTIVE] = outside_active_flag;
        out_status[ST_X] = x_outside_flag;
        out_status[ST_Y] = y_outside_flag;
        out_status[ST_Z] = z_outside_flag;
    end

    // Unmapped indices read zero
    wire [DAT_W-1:0] rd_mux =
        hit_win_st ? {24'h00_0000, win_status} :
        hit_out_st ? {24'h00_0000, out_status} :
        hit_cfg ? {24'h00_0000, change_detect_config_a} :
        hit_upper ? DAT_W'($unsigned(upper_threshold)) :
        hit_lower ? DAT_W'($unsigned(lower_threshold)) :
        hit_in_db ? {24'h00_0000, inside_debounce_count} :
        hit_out_db ? {24'h00_0000, outside_debounce_count} :
        32'h0000_0000;

    // Strap passes three stages before use
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            strap_s3 <= 1'b0;
        end else if (ce) begin
            strap_s1 <= boot_strap_pin;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
        end
    end

    // Strap loads config after release; software write preempts it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            boot_state <= BOOT_SETTLE;
            settle <= 2'h0;
        end else if (ce) begin
            case (boot_state)
                BOOT_SETTLE: begin
                    if (wr_cfg) begin
                        boot_state <= BOOT_RUN;
                    end else if (settle_done && strap_stable) begin
                        boot_state <= BOOT_RUN;
                    end else if (!settle_done) begin
                        settle <= settle + 2'h1;
                    end
                end
                default: begin
                    boot_state <= BOOT_RUN;
                end
            endcase
        end
    end

    wire boot_load = (boot_state == BOOT_SETTLE) && settle_done && strap_stable && !wr_cfg;
    wire [7:0] cfg_boot_value = strap_s3 ? CFG_RESET_STRAP_HIGH : CFG_RESET_STRAP_LOW;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            change_detect_config_a <= CFG_RESET_STRAP_LOW;
        end else if (ce) begin
            if (wr_cfg) begin
                change_detect_config_a <= wb_dat_w[7:0];
            end else if (boot_load) begin
                change_detect_config_a <= cfg_boot_value;
            end
        end
    end

    // Thresholds keep their reset value until written
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            upper_threshold <= '0;
        end else if (ce && wr_upper) begin
            upper_threshold <= thr_wdata;
        end
    end

    // Lower bound, signed like the upper
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lower_threshold <= '0;
        end else if (ce && wr_lower) begin
            lower_threshold <= thr_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            inside_debounce_count <= DB_RESET;
        end else if (ce && wr_in_db) begin
            inside_debounce_count <= wb_dat_w[DB_W-1:0];
        end
    end

    // Outside count only gates the outside class
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            outside_debounce_count <= DB_RESET;
        end else if (ce && wr_out_db) begin
            outside_debounce_count <= wb_dat_w[DB_W-1:0];
        end
    end

    // One-cycle answer; a held strobe is not taken twice
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wb_ack <= 1'b0;
        end else if (ce) begin
            wb_ack <= req;
        end
    end

    // Read data stands until the next read
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wb_dat_r <= 32'h0000_0000;
        end else if (ce && rd) begin
            wb_dat_r <= rd_mux;
        end
    end
endmodule : tefl_flag_latch

// ### tefl_flag_latch_sva.sv
module tefl_flag_latch_sva
    import tefl_pkg::*;
#(
    parameter int AXIS_W = 12
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic boot_strap_pin,
    input wire logic sample_valid,
    input wire logic [AXIS_W-1:0] axis_x,
    input wire logic [AXIS_W-1:0] axis_y,
    input wire logic [AXIS_W-1:0] axis_z,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [DAT_W-1:0] wb_dat_w,
    input wire logic [DAT_W-1:0] wb_dat_r,
    input wire logic wb_ack,
    input wire logic inside_active_flag,
    input wire logic outside_active_flag
);
    // Frozen cycles prove nothing, so ce low disables
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn || !ce);
    wire req = wb_cyc && wb_stb && !wb_ack;
    property p_ack_resp; req |=> wb_ack; endproperty
    property p_ack_pulse; wb_ack |=> !wb_ack; endproperty
    property p_ack_idle; !(wb_cyc && wb_stb) |=> !wb_ack; endproperty
    property p_dat_hold; !(req && !wb_we) |=> $stable(wb_dat_r); endproperty
    property p_in_hold; !sample_valid && !(wb_cyc && wb_stb) |=> $stable(inside_active_flag); endproperty
    property p_out_hold; !sample_valid && !(wb_cyc && wb_stb) |=> $stable(outside_active_flag); endproperty
    property p_in_rise; $rose(inside_active_flag) |-> $past(sample_valid); endproperty
    property p_out_rise; $rose(outside_active_flag) |-> $past(sample_valid); endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not acked next cycle");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved without read");
    a_in_hold: assert property (p_in_hold) else $error("inside active moved between ticks");
    a_out_hold: assert property (p_out_hold) else $error("outside active moved between ticks");
    a_in_rise: assert property (p_in_rise) else $error("inside active rose without tick");
    a_out_rise: assert property (p_out_rise) else $error("outside active rose without tick");
    c_in_rise: cover property ($rose(inside_active_flag));
    c_out_rise: cover property ($rose(outside_active_flag));
    c_status_rd: cover property (req && !wb_we && wb_adr[9:2] == IDX_WINDOW_STATUS);
endmodule : tefl_flag_latch_sva

bind tefl_flag_latch tefl_flag_latch_sva #(.AXIS_W(AXIS_W)) i_tefl_flag_latch_sva (.clk_sys, .resetn, .ce,
    .boot_strap_pin, .sample_valid, .axis_x, .axis_y, .axis_z, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
    .wb_dat_w, .wb_dat_r, .wb_ack, .inside_active_flag, .outside_active_flag);

// ### test_threshold_event_flag_latch.sv
module test_threshold_event_flag_latch
    import tefl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b1;
    logic sv = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] ax = 12'h000, ay = 12'h000, az = 12'h000;
    logic [ADR_W-1:0] adr = '0;
    logic [DAT_W-1:0] dw = '0;
    logic [DAT_W-1:0] rdat;
    wire logic [DAT_W-1:0] dr;
    wire logic ack, ia, oa;
    int n_mismatch = 0, n_compared = 0, cycles = 0;

    tefl_flag_latch #(.AXIS_W(12)) i_tefl_flag_latch (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
        .boot_strap_pin(strap), .sample_valid(sv), .axis_x(ax), .axis_y(ay), .axis_z(az), .wb_cyc(cyc),
        .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(4'h1), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack),
        .inside_active_flag(ia), .outside_active_flag(oa));

    always #2 clk_sys = ~clk_sys;

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // Ceiling far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dw <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        rdat = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0000_0000);
        chk(rdat, e);
    endtask : rd

    task automatic tick(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(posedge clk_sys);
        ax <= x;
        ay <= y;
        az <= z;
        sv <= 1'b1;
        @(posedge clk_sys);
        sv <= 1'b0;
        @(posedge clk_sys);
    endtask : tick

    task automatic t_config;
        repeat (6) @(posedge clk_sys);
        rd(IDX_CONFIG_A, 32'h0000_0038);
        rd(8'h7F, 32'h0000_0000);
        bus(1'b1, IDX_CONFIG_A, 32'h0000_00FF);
        rd(IDX_CONFIG_A, 32'h0000_00FF);
        @(posedge clk_sys);
        resetn <= 1'b0;
        strap <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(IDX_CONFIG_A, 32'h0000_0000);
        bus(1'b1, IDX_UPPER_THRESHOLD, 32'h0000_0064);
        bus(1'b1, IDX_LOWER_THRESHOLD, 32'h0000_0F9C);
    endtask : t_config

    task automatic t_inside;
        bus(1'b1, IDX_CONFIG_A, 32'h0000_0007);
        tick(12'h063, 12'h063, 12'h063);
        rd(IDX_WINDOW_STATUS, 32'h0000_00AA);
        tick(12'h064, 12'h000, 12'h063);
        rd(IDX_WINDOW_STATUS, 32'h0000_008A);
        tick(12'h000, 12'h064, 12'hF9C);
        rd(IDX_WINDOW_STATUS, 32'h0000_00A0);
        tick(12'h064, 12'h064, 12'h064);
        rd(IDX_WINDOW_STATUS, 32'h0000_0000);
        tick(12'hF9D, 12'hF9D, 12'hF9D);
        chk(ia, 1'b1);
        tick(12'hF9C, 12'hF9C, 12'hF9C);
        rd(IDX_WINDOW_STATUS, 32'h0000_0000);
        bus(1'b1, IDX_INSIDE_DEBOUNCE, 32'h0000_0002);
        tick(12'h000, 12'h000, 12'h000);
        rd(IDX_WINDOW_STATUS, 32'h0000_0000);
        tick(12'h000, 12'h000, 12'h000);
        rd(IDX_WINDOW_STATUS, 32'h0000_00AA);
        tick(12'h064, 12'h064, 12'h064);
        rd(IDX_WINDOW_STATUS, 32'h0000_002A);
        bus(1'b1, IDX_INSIDE_DEBOUNCE, 32'h0000_0000);
    endtask : t_inside

    task automatic t_inside_latch;
        bus(1'b1, IDX_CONFIG_A, 32'h0000_0047);
        tick(12'h064, 12'h064, 12'h064);
        bus(1'b0, IDX_WINDOW_STATUS, 32'h0000_0000);
        tick(12'h000, 12'h000, 12'h000);
        chk(ia, 1'b1);
        rd(IDX_WINDOW_STATUS, 32'h0000_00AA);
        rd(IDX_WINDOW_STATUS, 32'h0000_0000);
        tick(12'h000, 12'h000, 12'h000);
        rd(IDX_WINDOW_STATUS, 32'h0000_0000);
        tick(12'h064, 12'h064, 12'h064);
        tick(12'h000, 12'h000, 12'h000);
        rd(IDX_WINDOW_STATUS, 32'h0000_00AA);
    endtask : t_inside_latch

    task automatic t_outside;
        bus(1'b1, IDX_CONFIG_A, 32'h0000_0038);
        tick(12'h0C8, 12'h0C8, 12'h0C8);
        rd(IDX_OUTSIDE_STATUS, 32'h0000_00AA);
        tick(12'h000, 12'h0C8, 12'h000);
        rd(IDX_OUTSIDE_STATUS, 32'h0000_0088);
        tick(12'h000, 12'h000, 12'h000);
        rd(IDX_OUTSIDE_STATUS, 32'h0000_0000);
        bus(1'b1, IDX_CONFIG_A, 32'h0000_00B8);
        tick(12'h0C8, 12'h0C8, 12'h0C8);
        chk(oa, 1'b1);
        tick(12'h000, 12'h000, 12'h000);
        rd(IDX_OUTSIDE_STATUS, 32'h0000_00AA);
        rd(IDX_OUTSIDE_STATUS, 32'h0000_0000);
        tick(12'h0C8, 12'h0C8, 12'h0C8);
        bus(1'b0, IDX_OUTSIDE_STATUS, 32'h0000_0000);
        tick(12'h0C8, 12'h0C8, 12'h0C8);
        rd(IDX_OUTSIDE_STATUS, 32'h0000_0000);
        bus(1'b1, IDX_CONFIG_A, 32'h0000_0020);
        tick(12'h000, 12'h0C8, 12'h0C8);
        chk(oa, 1'b0);
        tick(12'h0C8, 12'h000, 12'h000);
        chk(oa, 1'b1);
    endtask : t_outside

    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_config();
        t_inside();
        t_inside_latch();
        t_outside();
        finish_test();
    end
endmodule : test_threshold_event_flag_latch
